// ===== core/edt_pkg.sv
// constants for the excitation dac code and trim register bank
`default_nettype none
package edt_pkg;
    localparam int unsigned ADDR_W          = 14;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned CODE_W          = 12;
    localparam logic [13:0] OFS_CODE        = 14'h2048;
    localparam logic [13:0] OFS_CONFIG      = 14'h2010;
    localparam logic [13:0] OFS_KEY         = 14'h2230;
    localparam logic [13:0] OFS_GAIN        = 14'h2260;
    localparam logic [13:0] OFS_OFF_ON_LP   = 14'h2264;
    localparam logic [13:0] OFS_OFF_OFF_LP  = 14'h2268;
    localparam logic [13:0] OFS_OFF_ON_HS   = 14'h22B8;
    localparam logic [13:0] OFS_OFF_OFF_HS  = 14'h22BC;
    localparam logic [13:0] OFS_MODE        = 14'h22C0;
    localparam logic [31:0] UNLOCK_KEY      = 32'hDE87A5AF;
    localparam logic [31:0] KEY_RST         = 32'hDE87A5A0;
    localparam logic [11:0] CODE_RST        = 12'h800;
    localparam logic [11:0] GAIN_RST        = 12'h800;
    localparam logic [11:0] OFF_RST         = 12'h000;
    localparam logic [31:0] CONFIG_RST      = 32'h0000001E;
    localparam logic [31:0] CONFIG_MASK     = 32'h00001FFF;
    localparam int unsigned CFG_ATTEN_BIT   = 0;
    localparam int unsigned CFG_GAINSEL_BIT = 12;
    localparam int unsigned MODE_HS_BIT     = 0;
    localparam logic [31:0] RD_UNMAPPED     = 32'h00000000;
endpackage
`default_nettype wire

// ===== core/edt_regs.sv
// excitation dac code, unlock key, gain and offset trim register bank
`timescale 1ns/1ps
`default_nettype none
module edt_regs
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [13:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output var  logic [11:0] dac_code_field,
    output var  logic [11:0] gain_trim_out,
    output var  logic [11:0] offset_trim_out,
    output var  logic        output_attenuator_enable,
    output var  logic        excitation_gain_select,
    output var  logic        trims_unlocked
);
    ////////////////////////////////////////////////////////////////////////
    logic [11:0] code_r, code_nxt;
    logic [31:0] key_r, key_nxt;
    logic [31:0] cfg_r, cfg_nxt;
    logic        hs_r, hs_nxt;
    logic [11:0] gain_r, gain_nxt;
    logic [11:0] off_r [4];
    logic [11:0] off_nxt [4];
    logic [31:0] rdata_r, rdata_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] bmask;
    logic [31:0] wmerge_key, wmerge_cfg;
    logic [11:0] wmerge12 [6];
    logic        unlocked;
    logic        wr_go;

    // one wait cycle per access, then the answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go           = avs_write & ack_r;
    assign unlocked        = (key_r == edt_pkg::UNLOCK_KEY);

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_lane
            assign bmask[gb*8 +: 8] = {8{avs_byteenable[gb]}};
        end
    endgenerate

    assign wmerge_key = (key_r & ~bmask) | (avs_writedata & bmask);
    assign wmerge_cfg = ((cfg_r & ~bmask) | (avs_writedata & bmask))
                        & edt_pkg::CONFIG_MASK;
    assign wmerge12[0] = (code_r & ~bmask[11:0])
                         | (avs_writedata[11:0] & bmask[11:0]);
    assign wmerge12[1] = (gain_r & ~bmask[11:0])
                         | (avs_writedata[11:0] & bmask[11:0]);

    genvar go;
    generate
        for (go = 0; go < 4; go++)
        begin : g_offm
            assign wmerge12[go+2] = (off_r[go] & ~bmask[11:0])
                                    | (avs_writedata[11:0] & bmask[11:0]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // register writes; offsets 0 on/lp, 1 off/lp, 2 on/hs, 3 off/hs
    always_comb
    begin
        code_nxt = code_r;
        key_nxt  = key_r;
        cfg_nxt  = cfg_r;
        hs_nxt   = hs_r;
        gain_nxt = gain_r;
        for (int i = 0; i < 4; i++)
        begin
            off_nxt[i] = off_r[i];
        end
        if (wr_go)
        begin
            unique case (avs_address)
                edt_pkg::OFS_CODE:   code_nxt = wmerge12[0];
                edt_pkg::OFS_KEY:    key_nxt  = wmerge_key;
                edt_pkg::OFS_CONFIG: cfg_nxt  = wmerge_cfg;
                edt_pkg::OFS_MODE:
                    if (avs_byteenable[0])
                    begin
                        hs_nxt = avs_writedata[edt_pkg::MODE_HS_BIT];
                    end
                edt_pkg::OFS_GAIN:
                    if (unlocked)
                    begin
                        gain_nxt = wmerge12[1];
                    end
                edt_pkg::OFS_OFF_ON_LP:
                    if (unlocked)
                    begin
                        off_nxt[0] = wmerge12[2];
                    end
                edt_pkg::OFS_OFF_OFF_LP:
                    if (unlocked)
                    begin
                        off_nxt[1] = wmerge12[3];
                    end
                edt_pkg::OFS_OFF_ON_HS:
                    if (unlocked)
                    begin
                        off_nxt[2] = wmerge12[4];
                    end
                edt_pkg::OFS_OFF_OFF_HS:
                    if (unlocked)
                    begin
                        off_nxt[3] = wmerge12[5];
                    end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            code_r <= edt_pkg::CODE_RST;
            key_r  <= edt_pkg::KEY_RST;
            cfg_r  <= edt_pkg::CONFIG_RST;
            hs_r   <= 1'b0;
            gain_r <= edt_pkg::GAIN_RST;
            for (int i = 0; i < 4; i++)
            begin
                off_r[i] <= edt_pkg::OFF_RST;
            end
        end
        else
        begin
            code_r <= code_nxt;
            key_r  <= key_nxt;
            cfg_r  <= cfg_nxt;
            hs_r   <= hs_nxt;
            gain_r <= gain_nxt;
            for (int i = 0; i < 4; i++)
            begin
                off_r[i] <= off_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer: read data registered with the ack
    always_comb
    begin
        ack_nxt   = (avs_read | avs_write) & ~ack_r;
        rdata_nxt = rdata_r;
        if (avs_read & ~ack_r)
        begin
            unique case (avs_address)
                edt_pkg::OFS_CODE:       rdata_nxt = {20'h00000, code_r};
                edt_pkg::OFS_KEY:        rdata_nxt = key_r;
                edt_pkg::OFS_CONFIG:     rdata_nxt = cfg_r;
                edt_pkg::OFS_MODE:       rdata_nxt = {31'h00000000, hs_r};
                edt_pkg::OFS_GAIN:       rdata_nxt = {20'h00000, gain_r};
                edt_pkg::OFS_OFF_ON_LP:  rdata_nxt = {20'h00000, off_r[0]};
                edt_pkg::OFS_OFF_OFF_LP: rdata_nxt = {20'h00000, off_r[1]};
                edt_pkg::OFS_OFF_ON_HS:  rdata_nxt = {20'h00000, off_r[2]};
                edt_pkg::OFS_OFF_OFF_HS: rdata_nxt = {20'h00000, off_r[3]};
                default:                 rdata_nxt = edt_pkg::RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // trim selection toward the analog chain
    logic       atten, hs_sel;
    logic [1:0] sel;
    assign atten  = cfg_r[edt_pkg::CFG_ATTEN_BIT];
    assign hs_sel = hs_r;
    // gain select bit does not enter the choice
    assign sel    = {hs_sel, ~atten};

    assign dac_code_field           = code_r;
    assign gain_trim_out            = gain_r;
    assign offset_trim_out          = off_r[sel];
    assign output_attenuator_enable = atten;
    assign excitation_gain_select   = cfg_r[edt_pkg::CFG_GAINSEL_BIT];
    assign trims_unlocked           = unlocked;

    ////////////////////////////////////////////////////////////////////////
    sequence s_unlocked_wr;
        wr_go && unlocked;
    endsequence

    sequence s_locked_wr;
        wr_go && !unlocked;
    endsequence

    a_code_direct: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        wr_go && avs_address == edt_pkg::OFS_CODE && avs_byteenable == 4'hF
        |=> dac_code_field == $past(avs_writedata[11:0]))
        else $error("code write not passed to converter");

    a_code_steady: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !(wr_go && avs_address == edt_pkg::OFS_CODE)
        |=> $stable(dac_code_field))
        else $error("code changed without a code write");

    a_gain_locked: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_locked_wr ##0 (avs_address == edt_pkg::OFS_GAIN)
        |=> $stable(gain_r))
        else $error("gain trim changed while locked");

    a_gain_unlocked: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_unlocked_wr ##0 (avs_address == edt_pkg::OFS_GAIN
        && avs_byteenable == 4'hF)
        |=> gain_trim_out == $past(avs_writedata[11:0]))
        else $error("gain trim not written while unlocked");

    a_offset_locked: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_locked_wr |=> $stable(off_r[0]) && $stable(off_r[1])
        && $stable(off_r[2]) && $stable(off_r[3]))
        else $error("offset trim changed while locked");

    a_hs_offset_wr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_unlocked_wr ##0 (avs_address == edt_pkg::OFS_OFF_ON_HS
        && avs_byteenable == 4'hF)
        |=> off_r[2] == $past(avs_writedata[11:0]))
        else $error("high speed offset not written while unlocked");

    a_key_unlock: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        wr_go && avs_address == edt_pkg::OFS_KEY && avs_byteenable == 4'hF
        |=> trims_unlocked == ($past(avs_writedata) == edt_pkg::UNLOCK_KEY))
        else $error("key compare wrong");

    a_key_relock: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_unlocked_wr ##0 (avs_address == edt_pkg::OFS_KEY
        && avs_writedata != edt_pkg::UNLOCK_KEY && avs_byteenable == 4'hF)
        |=> !trims_unlocked)
        else $error("key did not relock");

    a_key_readback: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ack_r && avs_read && avs_address == edt_pkg::OFS_KEY
        |-> avs_readdata == key_r)
        else $error("key did not read back");

    a_offset_sel: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        offset_trim_out == (atten ? (hs_r ? off_r[2] : off_r[0])
                                  : (hs_r ? off_r[3] : off_r[1])))
        else $error("wrong offset trim selected");

    a_upper_zero: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ack_r && avs_read && avs_address == edt_pkg::OFS_GAIN
        |-> avs_readdata[31:12] == 20'h00000)
        else $error("reserved bits read nonzero");

    a_code_upper: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ack_r && avs_read && avs_address == edt_pkg::OFS_CODE
        |-> avs_readdata[31:12] == 20'h00000)
        else $error("reserved code bits read nonzero");

    a_wait_one: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (avs_read || avs_write) && !ack_r |-> avs_waitrequest ##1 ack_r)
        else $error("bus answer not after one wait");
endmodule // edt_regs
`default_nettype wire

// ===== verif/edt_regs_tb.sv
// self-checking bench for the excitation dac code and trim register bank
`timescale 1ns/1ps
`default_nettype none
module edt_regs_tb;
    typedef struct packed
    {
        logic [13:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } edt_row_type;
    logic        sys_clk;
    logic        sys_rst;
    logic [13:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] dac_code_field;
    logic [11:0] gain_trim_out;
    logic [11:0] offset_trim_out;
    logic        output_attenuator_enable;
    logic        excitation_gain_select;
    logic        trims_unlocked;
    logic [31:0] rdat;
    logic [11:0] exp12;
    int          n_mismatch;
    int          compares;
    edt_row_type rows [8];
    edt_regs dut
    (
        .sys_clk                  (sys_clk),
        .sys_rst                  (sys_rst),
        .avs_address              (avs_address),
        .avs_read                 (avs_read),
        .avs_write                (avs_write),
        .avs_writedata            (avs_writedata),
        .avs_byteenable           (avs_byteenable),
        .avs_readdata             (avs_readdata),
        .avs_waitrequest          (avs_waitrequest),
        .dac_code_field           (dac_code_field),
        .gain_trim_out            (gain_trim_out),
        .offset_trim_out          (offset_trim_out),
        .output_attenuator_enable (output_attenuator_enable),
        .excitation_gain_select   (excitation_gain_select),
        .trims_unlocked           (trims_unlocked)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %0t port %h expected %h", $time, got, exp);
        end
    endtask
    // one access; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [13:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        // waitrequest and read data as sampled at each rising edge
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge sys_clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #20000;
        n_mismatch++;
        $display("Error %0t watchdog expired", $time);
        finish_test();
    end
    initial
    begin
        sys_rst        = 1'b1;
        avs_address    = 14'h0000;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'hF;
        n_mismatch     = 0;
        compares       = 0;
        rows[0] = {edt_pkg::OFS_KEY, edt_pkg::UNLOCK_KEY, edt_pkg::UNLOCK_KEY};
        rows[1] = {edt_pkg::OFS_CODE, 32'hFFFFFE00, 32'h00000E00};
        rows[2] = {edt_pkg::OFS_GAIN, 32'hABCD0FFF, 32'h00000FFF};
        rows[3] = {edt_pkg::OFS_OFF_ON_LP, 32'hFFFFF7FF, 32'h000007FF};
        rows[4] = {edt_pkg::OFS_OFF_OFF_LP, 32'h00000800, 32'h00000800};
        rows[5] = {edt_pkg::OFS_OFF_ON_HS, 32'h00000001, 32'h00000001};
        rows[6] = {edt_pkg::OFS_OFF_OFF_HS, 32'h00000FFF, 32'h00000FFF};
        rows[7] = {14'h2100, 32'h12345678, edt_pkg::RD_UNMAPPED};
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, rows[i].addr, rows[i].wdata, rdat);
            bus(1'b0, rows[i].addr, 32'h00000000, rdat);
            chk_rd(rdat, rows[i].exp);
        end
        chk_out(dac_code_field, 12'hE00);
        $display("test rows done");
        // every attenuator, power mode and gain select combination
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, edt_pkg::OFS_CONFIG, {19'h0, k[2], 11'h0, k[0]}, rdat);
            bus(1'b1, edt_pkg::OFS_MODE, {31'h0, k[1]}, rdat);
            @(negedge sys_clk);
            exp12 = k[0] ? (k[1] ? 12'h001 : 12'h7FF)
                         : (k[1] ? 12'hFFF : 12'h800);
            chk_out(offset_trim_out, exp12);
            chk_out({11'h0, output_attenuator_enable}, {11'h0, k[0]});
            chk_out({11'h0, excitation_gain_select}, {11'h0, k[2]});
            chk_out(gain_trim_out, 12'hFFF);
        end
        $display("test offset select done");
        bus(1'b1, edt_pkg::OFS_KEY, 32'h00000000, rdat);
        bus(1'b0, edt_pkg::OFS_KEY, 32'h00000000, rdat);
        chk_rd(rdat, 32'h00000000);
        chk_out({11'h0, trims_unlocked}, 12'h000);
        bus(1'b1, edt_pkg::OFS_GAIN, 32'h00000123, rdat);
        bus(1'b1, edt_pkg::OFS_OFF_ON_HS, 32'h00000456, rdat);
        bus(1'b1, edt_pkg::OFS_OFF_OFF_LP, 32'h00000789, rdat);
        bus(1'b0, edt_pkg::OFS_GAIN, 32'h00000000, rdat);
        chk_rd(rdat, 32'h00000FFF);
        bus(1'b0, edt_pkg::OFS_OFF_ON_HS, 32'h00000000, rdat);
        chk_rd(rdat, 32'h00000001);
        bus(1'b0, edt_pkg::OFS_OFF_OFF_LP, 32'h00000000, rdat);
        chk_rd(rdat, 32'h00000800);
        bus(1'b1, edt_pkg::OFS_CODE, 32'h00000200, rdat);
        @(negedge sys_clk);
        chk_out(dac_code_field, 12'h200);
        // single byte lane write merges into the code field
        avs_byteenable <= 4'h1;
        bus(1'b1, edt_pkg::OFS_CODE, 32'h00000EAB, rdat);
        avs_byteenable <= 4'hF;
        bus(1'b0, edt_pkg::OFS_CODE, 32'h00000000, rdat);
        chk_rd(rdat, 32'h000002AB);
        $display("test lock done");
        // second reset in mid-run
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk_out(dac_code_field, edt_pkg::CODE_RST);
        chk_out({11'h0, trims_unlocked}, 12'h000);
        chk_out(offset_trim_out, 12'h000);
        bus(1'b0, edt_pkg::OFS_CONFIG, 32'h00000000, rdat);
        chk_rd(rdat, edt_pkg::CONFIG_RST);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, rows[i].addr, 32'h00000000, rdat);
            chk_rd(rdat, i == 0 ? edt_pkg::KEY_RST
                       : (i < 3 ? 32'h00000800 : 32'h00000000));
        end
        bus(1'b1, edt_pkg::OFS_OFF_OFF_HS, 32'h00000321, rdat);
        bus(1'b0, edt_pkg::OFS_OFF_OFF_HS, 32'h00000000, rdat);
        chk_rd(rdat, 32'h00000000);
        $display("test reset done");
        finish_test();
    end
endmodule // edt_regs_tb
`default_nettype wire
